// >>> fp_handler_model.sv
// handler model: avalon-mm master that reads the saved frame and picks its layout
// assumes the capture block answers each request with waitrequest low
`timescale 1ns/1ps
module fp_handler_model
  import fp_inexact_pkg::*;
(
  // clock
  input  wire logic        sys_clk_i,
  // master side of the bus
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  // idle bus from time zero
  initial
  begin
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // one access; a random idle gap makes the handler prompt or slow
  task automatic xfer(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    repeat ($urandom_range(2, 0) + 1) @(posedge sys_clk_i);
    avs_address   <= adr;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge sys_clk_i);
    // held until waitrequest is sampled low; only the bench watchdog ends a hang
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk_i);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // third stage layout wins when both valid flags are set
  task automatic pick_layout(output logic [1:0] lay);
    logic [31:0] f;
    xfer(1'b0, OFS_FLAGS, 32'h0000_0000, f);
    lay = f[FLG_THIRD_VALID] ? 2'h3 : {1'b0, f[FLG_FIRST_VALID]};
  endtask
endmodule

// >>> fp_inexact_checker.sv
// assertion checker for the inexact frame capture block
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
module fp_inexact_checker
  import fp_inexact_pkg::*;
(
  // clock and reset
  input wire logic               sys_clk_i,
  input wire logic               arst_n_i,
  // event side
  input wire logic               inexact_exception_i,
  input wire logic [1:0]         inexact_exception_case_i,
  input wire logic [15:0]        cmd_word_i,
  input wire logic [15:0]        encoded_cmd_i,
  input wire logic [IMANT_W-1:0] result_mant_i,
  // bus side
  input wire logic [5:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [1:0]  cs_q;   // case of the last event
  logic [15:0] cw_q;   // its command word
  logic [15:0] ec_q;   // its encoded command
  logic [2:0]  gr_q;   // its guard, round, sticky
  logic        ev_q;   // an event was seen
  logic [3:0]  age_q;  // cycles since it, saturating
  logic        rd_ok;  // read answered after the frame walk

  // capture the expected frame; a new event restarts the age, as the walk restarts
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cs_q  <= 2'h0;
      cw_q  <= 16'h0;
      ec_q  <= 16'h0;
      gr_q  <= 3'h0;
      ev_q  <= 1'b0;
      age_q <= 4'h0;
    end
    else if (inexact_exception_i)
    begin
      cs_q  <= inexact_exception_case_i;
      cw_q  <= cmd_word_i;
      ec_q  <= encoded_cmd_i;
      gr_q  <= result_mant_i[2:0];
      ev_q  <= 1'b1;
      age_q <= 4'h0;
    end
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end
  assign rd_ok = avs_read && !avs_waitrequest && ev_q && (age_q > 4'h9);

  property p_answer;
    $rose(avs_read || avs_write) |-> avs_waitrequest[*2] ##1 !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late or early");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_flags_reg;
    rd_ok && avs_address == OFS_FLAGS && cs_q == 2'h0 |-> avs_readdata[6:0] == 7'h01;
  endproperty
  a_flags_reg: assert property (p_flags_reg) else $error("reg move flags wrong");
  property p_flags_ar;
    rd_ok && avs_address == OFS_FLAGS && cs_q == 2'h1 |-> avs_readdata[1:0] == 2'h2;
  endproperty
  a_flags_ar: assert property (p_flags_ar) else $error("arith flags wrong");
  property p_flags_mem;
    rd_ok && avs_address == OFS_FLAGS && cs_q == 2'h2 |-> avs_readdata[6:0] == 7'h05;
  endproperty
  a_flags_mem: assert property (p_flags_mem) else $error("mem move flags wrong");
  property p_cmd1;
    rd_ok && avs_address == OFS_CMD1 && cs_q != 2'h1 |-> avs_readdata[15:0] == cw_q;
  endproperty
  a_cmd1: assert property (p_cmd1) else $error("first stage command wrong");
  property p_cmd3;
    rd_ok && avs_address == OFS_CMD3 && cs_q == 2'h1 |-> avs_readdata[15:0] == ec_q;
  endproperty
  a_cmd3: assert property (p_cmd3) else $error("third stage command wrong");
  property p_grs;
    rd_ok && avs_address == OFS_WB_LO && cs_q == 2'h1 |-> avs_readdata[1:0] == gr_q[2:1];
  endproperty
  a_grs: assert property (p_grs) else $error("guard and round bits wrong");

  // main scenarios
  c_arith: cover property (rd_ok && avs_address == OFS_FLAGS && cs_q == 2'h1);
  c_mem: cover property (rd_ok && avs_address == OFS_FLAGS && cs_q == 2'h2);
  c_irq: cover property ($rose(irq_o));
endmodule

bind fp_inexact_state_frame fp_inexact_checker fp_inexact_checker_inst (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .inexact_exception_i(inexact_exception_i),
  .inexact_exception_case_i(inexact_exception_case_i), .cmd_word_i(cmd_word_i), .encoded_cmd_i(encoded_cmd_i),
  .result_mant_i(result_mant_i), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_o(irq_o)
);

// >>> fp_inexact_pkg.sv
// package for the inexact-result state frame capture block
// assumes a single processor clock domain and an avalon-mm register bus
package fp_inexact_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_STATUS   = 6'h00;  // sticky event bits, write one to clear
  localparam logic [5:0] OFS_MASK     = 6'h04;  // interrupt mask
  localparam logic [5:0] OFS_FLAGS    = 6'h08;  // stage valid flags, subtype, tag
  localparam logic [5:0] OFS_CMD1     = 6'h0c;  // first-stage command word
  localparam logic [5:0] OFS_CMD3     = 6'h10;  // third-stage encoded command
  localparam logic [5:0] OFS_TMP_EXP  = 6'h14;  // temp operand sign and exponent
  localparam logic [5:0] OFS_TMP_HI   = 6'h18;  // temp operand mantissa high
  localparam logic [5:0] OFS_TMP_LO   = 6'h1c;  // temp operand mantissa low
  localparam logic [5:0] OFS_WB_EXP   = 6'h20;  // writeback sign, exponent, sticky
  localparam logic [5:0] OFS_WB_HI    = 6'h24;  // writeback mantissa high
  localparam logic [5:0] OFS_WB_LO    = 6'h28;  // writeback mantissa low

  // flags register bit positions
  localparam int FLG_FIRST_VALID = 0;
  localparam int FLG_THIRD_VALID = 1;
  localparam int FLG_SUBTYPE     = 2;
  localparam int FLG_TAG_LSB     = 4;  // 3-bit source tag

  // status register bit positions
  localparam int ST_REG_MOVE = 0;
  localparam int ST_ARITH    = 1;
  localparam int ST_MEM_MOVE = 2;

  // writeback exponent word field positions
  localparam int WB_STICKY_POS = 16;
  localparam int WB_SIGN_POS   = 15;
  localparam int WB_EXP_MSB    = 14;

  // widths and encodings
  localparam int EXP_W   = 15;
  localparam int MANT_W  = 64;
  localparam int IMANT_W = 67;  // mantissa plus guard, round, sticky
  localparam logic [2:0] TAG_NORMALIZED = 3'h0;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_MASK = 3'h0;

  // exception case enumeration
  typedef enum logic [1:0] {
    CASE_REG_MOVE,
    CASE_ARITH,
    CASE_MEM_MOVE
  } inexact_exception_case_e;

endpackage

// >>> fp_inexact_state_frame.sv
// captures fpu internal state into a saved frame on an inexact-result event
// assumes the fpu pulses one event per exception with its data valid alongside
`timescale 1ns/1ps
module fp_inexact_state_frame
  import fp_inexact_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // exception event from the fpu
  input  wire logic                 inexact_exception_i,   // one-cycle pulse
  input  wire logic [1:0]           inexact_exception_case_i,           // inexact_exception_case_e code
  input  wire logic [15:0]          cmd_word_i,            // offending command word
  input  wire logic [15:0]          encoded_cmd_i,         // encoded arithmetic command
  input  wire logic                 result_sign_i,         // intermediate sign
  input  wire logic [EXP_W-1:0]     result_exp_i,          // biased exponent
  input  wire logic [IMANT_W-1:0]   result_mant_i,         // unrounded 67-bit mantissa
  input  wire logic                 subtype_hint_i,        // arithmetic subtype, free value
  // avalon-mm slave
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // interrupt
  output logic                      irq_o
);

  // frame store slots
  localparam logic [2:0] SLOT_CMD1 = 3'h0;
  localparam logic [2:0] SLOT_CMD3 = 3'h1;
  localparam logic [2:0] SLOT_TEXP = 3'h2;
  localparam logic [2:0] SLOT_THI  = 3'h3;
  localparam logic [2:0] SLOT_TLO  = 3'h4;
  localparam logic [2:0] SLOT_WEXP = 3'h5;
  localparam logic [2:0] SLOT_WHI  = 3'h6;
  localparam logic [2:0] SLOT_WLO  = 3'h7;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,   // frame store read in flight
    BUS_DONE    // answer presented, waitrequest low
  } bus_state_e;

  // capture sequencer walks the frame words one per cycle
  logic [3:0]          cap_cnt_q;        // 0 idle, else slot+1 being written
  inexact_exception_case_e          cap_case_q;       // latched case
  logic [15:0]         cap_cmd_q;        // latched command word
  logic [15:0]         cap_enc_q;        // latched encoded command
  logic                cap_sign_q;       // latched sign
  logic [EXP_W-1:0]    cap_exp_q;        // latched exponent
  logic [IMANT_W-1:0]  cap_mant_q;       // latched mantissa
  logic                cap_sub_q;        // latched subtype hint
  // frame flags
  logic                first_valid_q;
  logic                third_valid_q;
  logic                subtype_q;
  logic [2:0]          source_operand_tag_q;
  // interrupt registers
  logic [2:0]          status_q;
  logic [2:0]          mask_q;
  // bus
  bus_state_e          bus_q;
  logic                rd_mem_q;         // read targets frame store
  logic [31:0]         rd_reg_q;         // read data for flag/status registers
  // frame store port wires
  logic                mem_wr;
  logic [2:0]          mem_wsel;
  logic [31:0]         mem_wdata;
  logic [31:0]         mem_rdata;
  logic [2:0]          mem_rsel;
  logic [2:0]          evt;              // this cycle's event bits

  // map a bus offset to a frame store slot
  function automatic logic [2:0] slot_of(input logic [5:0] ofs);
    logic [5:0] d;
    d = ofs - OFS_CMD1;
    return d[4:2];
  endfunction

  // true when the offset lies in the frame store window
  function automatic logic in_frame(input logic [5:0] ofs);
    return (ofs >= OFS_CMD1) && (ofs <= OFS_WB_LO) && (ofs[1:0] == 2'h0);
  endfunction

  // latch event data; a new event restarts the capture walk
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cap_cnt_q  <= 4'h0;
      cap_case_q <= CASE_REG_MOVE;
      cap_cmd_q  <= 16'h0000;
      cap_enc_q  <= 16'h0000;
      cap_sign_q <= 1'b0;
      cap_exp_q  <= '0;
      cap_mant_q <= '0;
      cap_sub_q  <= 1'b0;
    end
    else if (inexact_exception_i)
    begin
      cap_cnt_q  <= 4'h1;
      cap_case_q <= inexact_exception_case_e'(inexact_exception_case_i);
      cap_cmd_q  <= cmd_word_i;
      cap_enc_q  <= encoded_cmd_i;
      cap_sign_q <= result_sign_i;
      cap_exp_q  <= result_exp_i;
      cap_mant_q <= result_mant_i;
      cap_sub_q  <= subtype_hint_i;
    end
    else if (cap_cnt_q != 4'h0)
    begin
      cap_cnt_q <= (cap_cnt_q == 4'h8) ? 4'h0 : cap_cnt_q + 4'h1;
    end
  end

  // word placed in each frame slot during the walk
  always_comb
  begin
    mem_wsel  = cap_cnt_q[2:0] - 3'h1;
    mem_wr    = (cap_cnt_q != 4'h0);
    mem_wdata = RST_WORD;
    unique case (mem_wsel)
      SLOT_CMD1:
        // register and memory moves keep the raw command word
        mem_wdata = (cap_case_q != CASE_ARITH) ? {16'h0000, cap_cmd_q} : RST_WORD;
      SLOT_CMD3:
        mem_wdata = (cap_case_q == CASE_ARITH) ? {16'h0000, cap_enc_q} : RST_WORD;
      SLOT_TEXP:
        // temp operand holds the unrounded intermediate for moves
        mem_wdata = (cap_case_q != CASE_ARITH) ?
                    {16'h0000, cap_sign_q, cap_exp_q} : RST_WORD;
      SLOT_THI:
        mem_wdata = (cap_case_q != CASE_ARITH) ? cap_mant_q[IMANT_W-1:IMANT_W-32] : RST_WORD;
      SLOT_TLO:
        mem_wdata = (cap_case_q != CASE_ARITH) ? cap_mant_q[IMANT_W-33:3] : RST_WORD;
      SLOT_WEXP:
        // sticky, sign, 15-bit exponent; the 15 bits above the sticky are left zero
        mem_wdata = (cap_case_q == CASE_ARITH) ?
                    {15'h0, cap_mant_q[0], cap_sign_q, cap_exp_q} : RST_WORD;
      SLOT_WHI:
        mem_wdata = (cap_case_q == CASE_ARITH) ? cap_mant_q[IMANT_W-1-:32] : RST_WORD;
      SLOT_WLO:
        // low two mantissa bits replaced by guard and round
        mem_wdata = (cap_case_q == CASE_ARITH) ?
                    {cap_mant_q[IMANT_W-33:5], cap_mant_q[2:1]} : RST_WORD;
      default:
        mem_wdata = RST_WORD;
    endcase
  end

  // stage flags follow the case at the event itself
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      first_valid_q        <= 1'b0;
      third_valid_q        <= 1'b0;
      subtype_q            <= 1'b0;
      source_operand_tag_q <= TAG_NORMALIZED;
    end
    else if (inexact_exception_i)
    begin
      unique case (inexact_exception_case_e'(inexact_exception_case_i))
        CASE_REG_MOVE:
        begin
          first_valid_q        <= 1'b1;
          third_valid_q        <= 1'b0;
          subtype_q            <= 1'b0;
          source_operand_tag_q <= TAG_NORMALIZED;
        end
        CASE_ARITH:
        begin
          first_valid_q <= 1'b0;
          third_valid_q <= 1'b1;
          subtype_q     <= subtype_hint_i;
        end
        CASE_MEM_MOVE:
        begin
          first_valid_q        <= 1'b1;
          third_valid_q        <= 1'b0;
          subtype_q            <= 1'b1;
          source_operand_tag_q <= TAG_NORMALIZED;
        end
        default:
        begin
          first_valid_q <= first_valid_q;           // illegal code ignored
        end
      endcase
    end
  end

  // per-case event bits
  always_comb
  begin
    evt = 3'h0;
    if (inexact_exception_i && inexact_exception_case_i <= 2'h2)
      evt[inexact_exception_case_i] = 1'b1;
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      status_q <= 3'h0;
    else if (bus_q == BUS_DONE && avs_write && avs_address == OFS_STATUS)
      status_q <= (status_q & ~avs_writedata[2:0]) | evt;
    else
      status_q <= status_q | evt;
  end

  // mask register
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mask_q <= RST_MASK;
    else if (bus_q == BUS_DONE && avs_write && avs_address == OFS_MASK)
      mask_q <= avs_writedata[2:0];
  end

  // interrupt level, registered
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_q & mask_q);
  end

  // bus handshake: two wait cycles, then one answer cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bus_q           <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      rd_mem_q        <= 1'b0;
      rd_reg_q        <= RST_WORD;
    end
    else
    begin
      unique case (bus_q)
        BUS_IDLE:
        begin
          avs_waitrequest <= 1'b1;
          if (avs_read || avs_write)
          begin
            bus_q    <= BUS_WAIT;
            rd_mem_q <= in_frame(avs_address);
            unique case (avs_address)
              OFS_STATUS: rd_reg_q <= {29'h0, status_q};
              OFS_MASK:   rd_reg_q <= {29'h0, mask_q};
              // handler reads both valid flags; third stage takes priority
              OFS_FLAGS:  rd_reg_q <= {25'h0, source_operand_tag_q, 1'b0,
                                       subtype_q, third_valid_q, first_valid_q};
              default:    rd_reg_q <= RST_WORD;  // unmapped reads zero
            endcase
          end
        end
        BUS_WAIT:
        begin
          bus_q           <= BUS_DONE;
          avs_waitrequest <= 1'b0;
        end
        BUS_DONE:
        begin
          bus_q           <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
          bus_q <= BUS_IDLE;
      endcase
    end
  end

  // read data mux, registered; store output is ready by the answer cycle
  assign mem_rsel = slot_of(avs_address);
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata <= RST_WORD;
    else if (bus_q == BUS_WAIT)
      avs_readdata <= rd_mem_q ? mem_rdata : rd_reg_q;
  end

  // frame word store
  frame_mem u_frame_mem (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (mem_wr),
    .wr_sel_i  (mem_wsel),
    .wr_data_i (mem_wdata),
    .rd_sel_i  (mem_rsel),
    .rd_data_o (mem_rdata)
  );

endmodule

// >>> fp_inexact_state_frame_tb.sv
// self-checking bench for the inexact frame capture block
// assumes design files come first; the handler model masters the bus
`timescale 1ns/1ps
module fp_inexact_state_frame_tb
  import fp_inexact_pkg::*;
;
  logic               sys_clk_i;
  logic               arst_n_i = 1'b0;
  logic               ex_pulse = 1'b0;  // event strobe
  logic [1:0]         ex_case  = 2'h0;  // event case
  logic [15:0]        cmd_w    = 16'h0; // command word
  logic [15:0]        enc_w    = 16'h0; // encoded command
  logic               sgn      = 1'b0;  // result sign
  logic [EXP_W-1:0]   expo     = '0;    // biased exponent
  logic [IMANT_W-1:0] mant     = '0;    // mantissa with guard, round, sticky
  logic               hint     = 1'b0;  // arith subtype value
  logic [5:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               irq_o;
  logic [31:0]        q;                // last word read
  logic [1:0]         lay;              // layout the handler chose
  int                 bad_count = 0;
  int                 compares  = 0;

  fp_inexact_state_frame fp_inexact_state_frame_inst (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .inexact_exception_i(ex_pulse), .inexact_exception_case_i(ex_case),
    .cmd_word_i(cmd_w), .encoded_cmd_i(enc_w), .result_sign_i(sgn), .result_exp_i(expo),
    .result_mant_i(mant), .subtype_hint_i(hint), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
  fp_handler_model fp_handler_model_inst (.sys_clk_i(sys_clk_i),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));

  // 20 mhz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    fp_handler_model_inst.xfer(wr, a, d, q);
  endtask

  // one-cycle event with fresh random data
  task automatic fire(input logic [1:0] c);
    @(posedge sys_clk_i);
    ex_pulse <= 1'b1;
    ex_case  <= c;
    cmd_w    <= 16'($urandom);
    enc_w    <= 16'($urandom);
    sgn      <= 1'($urandom);
    expo     <= 15'($urandom);
    mant     <= {3'($urandom), $urandom, $urandom};
    hint     <= 1'($urandom);
    @(posedge sys_clk_i);
    ex_pulse <= 1'b0;
  endtask

  // expected word; fields of the other cases are zero
  function automatic logic [31:0] exp_word(input logic [5:0] a);
    logic ar;
    ar = (ex_case == 2'h1);
    case (a)
      OFS_FLAGS:   exp_word = ar ? {29'h0, hint, 2'h2} : ((ex_case == 2'h2) ? 32'h5 : 32'h1);
      OFS_CMD1:    exp_word = ar ? 32'h0 : {16'h0, cmd_w};
      OFS_CMD3:    exp_word = ar ? {16'h0, enc_w} : 32'h0;
      OFS_TMP_EXP: exp_word = ar ? 32'h0 : {16'h0, sgn, expo};
      OFS_TMP_HI:  exp_word = ar ? 32'h0 : mant[66:35];
      OFS_TMP_LO:  exp_word = ar ? 32'h0 : mant[34:3];
      OFS_WB_EXP:  exp_word = ar ? {15'h0, mant[0], sgn, expo} : 32'h0;
      OFS_WB_HI:   exp_word = ar ? mant[66:35] : 32'h0;
      default:     exp_word = ar ? {mant[34:5], mant[2:1]} : 32'h0;  // guard, round at the bottom
    endcase
  endfunction

  task automatic check_frame();
    logic [5:0] a;
    for (int k = 0; k < 9; k++)
    begin
      a = OFS_FLAGS + 6'(4 * k);
      bus(1'b0, a, 32'h0);
      chk($sformatf("word %h", a), q, exp_word(a));
    end
    fp_handler_model_inst.pick_layout(lay);
    chk("layout", {30'h0, lay}, (ex_case == 2'h1) ? 32'h3 : 32'h1);
  endtask

  // sticky status, mask and level interrupt, cleared by writing one
  task automatic irq_test();
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", q, 32'h1);
    bus(1'b1, OFS_MASK, 32'h7);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq raised", {31'h0, irq_o}, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask

  // main sequence: refusals, every case, a restart in mid-walk, then random cases
  initial
  begin
    void'($urandom(32'ha9a7));
    repeat (12) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, 6'h3c, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'hffff_ffff);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags write ignored", q, RST_WORD);
    for (int i = 0; i < 16; i++)
    begin
      repeat ((i == 3) ? 2 : 1) fire((i < 3) ? 2'(i) : 2'($urandom_range(2, 0)));
      repeat (10) @(posedge sys_clk_i);
      check_frame();
      if (i == 0)
        irq_test();
    end
    conclude();
  end

  // watchdog, about five times the expected run
  initial
  begin
    #250000;
    bad_count++;
    conclude();
  end
endmodule

// >>> frame_mem.sv
// small register-backed store for the captured frame words
// assumes writes and reads on the same clock; read data are registered
`timescale 1ns/1ps
module frame_mem
  import fp_inexact_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // write port, one word per slot
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  wr_sel_i,
  input  wire logic [31:0] wr_data_i,
  // read port
  input  wire logic [2:0]  rd_sel_i,
  output logic      [31:0] rd_data_o
);

  logic [31:0] mem_q [0:7];  // eight frame words

  // storage with defined reset so reads never return unknowns
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < 8; i++)
        mem_q[i] <= RST_WORD;
    end
    else if (wr_en_i)
    begin
      mem_q[wr_sel_i] <= wr_data_i;
    end
  end

  // registered read, one cycle behind the select
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_data_o <= RST_WORD;
    else
      rd_data_o <= mem_q[rd_sel_i];
  end

endmodule
